// ===== scsd_pkg.sv
// constants for the system clock select and divide block
// Overview of operation
// - current-source field at bits 14-12, hardware updated, eight source codes
// - writable requested-source field at bits 10-8, same encoding
// - after reset both source fields load from initial-source configuration
// - primary mode config decodes 10 fast crystal, 01 crystal, 00 ext clock
// - erased configuration starts on fast RC with postscaler, code 111
// - software sets switch request bit 0; hardware clears it when done
// - set-only freeze bit 7 blocks switching only while fail monitor on
// - PLL lock bit 5 shows lock or timer; cleared on switch, non-PLL
// - clock fail bit 3 set by monitor; software may only clear it
// - drive bit 2 forces high-power secondary; ignored for digital input
// - enable bit 1 keeps the 32 kHz secondary oscillator on even while it is not the selected source
// - exit-on-interrupt bit 15 lets an interrupt clear slowdown enable
// - slowdown ratio bits 14-12 give 1:1 to 1:128, reset 1:8
// - slowdown enable bit 11 applies ratio, else ratio is 1:1
// - same postscaler ratios apply to low-power fast RC source
// - six-bit trim value bits 5-0, reset zero, steps need not be even
// - switches enter or leave primary but never change its submode
// - request for the current source is redundant: clear and abort
// - after ready and lock, wait 10 new-clock cycles, then commit
// - upper byte writes need 78h then 9Ah, lower byte 46h then 57h
// - switching needs switch config bit 1 clear; monitor needs both bits 0
package scsd_pkg;
    // register indexes on the plain port
    localparam logic [1:0] SCSD_OFS_OSC_CTRL = 2'h0;
    localparam logic [1:0] SCSD_OFS_CLK_DIV = 2'h1;
    localparam logic [1:0] SCSD_OFS_RC_TRIM = 2'h2;
    // oscillator_control field positions
    localparam int SCSD_POS_CUR = 12;
    localparam int SCSD_POS_REQ = 8;
    localparam int SCSD_POS_FREEZE = 7;
    localparam int SCSD_POS_LOCK = 5;
    localparam int SCSD_POS_CF = 3;
    localparam int SCSD_POS_SDRV = 2;
    localparam int SCSD_POS_SEN = 1;
    localparam int SCSD_POS_SWREQ = 0;
    // clock_divider field positions
    localparam int SCSD_POS_ROI = 15;
    localparam int SCSD_POS_DOZE = 12;
    localparam int SCSD_POS_SLOWDOWN_ENABLE = 11;
    localparam int SCSD_POS_FAST_RC_POSTSCALER = 8;
    // source codes
    localparam logic [2:0] SCSD_SRC_FRC = 3'h0;
    localparam logic [2:0] SCSD_SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SCSD_SRC_PRI = 3'h2;
    localparam logic [2:0] SCSD_SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SCSD_SRC_SEC = 3'h4;
    localparam logic [2:0] SCSD_SRC_LOW_POWER_RC_OSC = 3'h5;
    localparam logic [2:0] SCSD_SRC_LPFRC_DIV = 3'h6;
    localparam logic [2:0] SCSD_SRC_FRC_DIV = 3'h7;
    // primary submode codes
    localparam logic [1:0] SCSD_PM_HS = 2'h2;
    localparam logic [1:0] SCSD_PM_XT = 2'h1;
    localparam logic [1:0] SCSD_PM_EC = 2'h0;
    localparam logic [1:0] SCSD_PM_INT = 2'h3;
    // reset values
    localparam logic [2:0] SCSD_RST_SRC = 3'h7;
    localparam logic [2:0] SCSD_RST_DOZE = 3'h3;
    localparam logic [2:0] SCSD_RST_FAST_RC_POSTSCALER = 3'h1;
    localparam logic [5:0] SCSD_RST_TRIM = 6'h00;
    // unlock keys
    localparam logic [7:0] SCSD_KEY_HI_1 = 8'h78;
    localparam logic [7:0] SCSD_KEY_HI_2 = 8'h9A;
    localparam logic [7:0] SCSD_KEY_LO_1 = 8'h46;
    localparam logic [7:0] SCSD_KEY_LO_2 = 8'h57;
    // new-clock cycles before changeover
    localparam logic [3:0] SCSD_SETTLE_CYCLES = 4'hA;
    // shift for the top postscaler code, whose ratio is 256 rather than 128
    localparam logic [3:0] SCSD_DIV256_SHIFT = 4'h8;
endpackage

// ===== scsd_top.sv
// system clock source selection, switching and divider control
module scsd_top (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [1:0] i_wr_be,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic [2:0] i_cfg_initial_source,
    input wire logic [1:0] i_cfg_primary_mode,
    input wire logic [1:0] i_cfg_switch_enable,
    input wire logic i_cfg_secondary_high_power,
    input wire logic i_cfg_secondary_digital,
    input wire logic [7:0] i_src_ready,
    input wire logic i_pll_lock,
    input wire logic i_pll_timer_done,
    input wire logic i_new_clk_tick,
    input wire logic i_old_clk_tick,
    input wire logic i_clock_fail,
    input wire logic i_irq,
    output logic [2:0] o_source_sel,
    output logic [1:0] o_primary_mode,
    output logic [7:0] o_osc_enable,
    output logic o_pll_enable,
    output logic o_secondary_high_power,
    output logic o_fail_monitor_enable,
    output logic [2:0] o_slowdown_ratio,
    output logic [3:0] o_rc_div_shift,
    output logic [5:0] o_rc_trim_value
);
    import scsd_pkg::*;

    // ================
    // types
    typedef enum logic [4:0] {
        SCSD_ST_IDLE = 5'b00001,
        SCSD_ST_CHECK = 5'b00010,
        SCSD_ST_WAIT = 5'b00100,
        SCSD_ST_SETTLE = 5'b01000,
        SCSD_ST_SYNC = 5'b10000
    } scsd_state_t;

    typedef struct packed {
        logic cfg_done;
        logic [2:0] current_source_sel;
        logic [2:0] requested_source_sel;
        logic switch_request;
        logic selection_freeze;
        logic pll_locked;
        logic clock_fail_flag;
        logic secondary_drive_strength;
        logic secondary_osc_enable;
        logic slowdown_exit_on_irq;
        logic [2:0] slowdown_ratio;
        logic slowdown_enable;
        logic [2:0] fast_rc_postscaler;
        logic [5:0] rc_trim_value;
        logic [1:0] hi_unlock;
        logic [1:0] lo_unlock;
        scsd_state_t state;
        logic [3:0] settle_cnt;
        logic [15:0] rdata;
        logic [1:0] primary_mode;
        logic [7:0] osc_enable;
        logic pll_enable;
        logic sec_high_power;
        logic fsm_enable;
        logic [2:0] ratio_out;
        logic [3:0] div_shift;
    } scsd_regs_t;

    scsd_regs_t r_r;
    scsd_regs_t r_nxt;

    // ================
    // helpers
    function automatic logic scsd_uses_pll(input logic [2:0] src);
        scsd_uses_pll = (src == SCSD_SRC_FRC_PLL) || (src == SCSD_SRC_PRI_PLL);
    endfunction

    function automatic logic [7:0] scsd_onehot(input logic [2:0] src);
        scsd_onehot = 8'h01 << src;
    endfunction

    logic switch_allowed;
    logic monitor_on;
    logic frozen;
    logic wr_osc;
    logic wr_div;
    logic wr_trim;
    logic hi_open;
    logic lo_open;
    logic switching;

    assign switch_allowed = ~i_cfg_switch_enable[1];
    assign monitor_on = (i_cfg_switch_enable == 2'h0);
    // freeze counts only while the monitor runs
    assign frozen = r_r.selection_freeze & monitor_on;
    assign wr_osc = i_wr & (i_addr == SCSD_OFS_OSC_CTRL);
    assign wr_div = i_wr & (i_addr == SCSD_OFS_CLK_DIV);
    assign wr_trim = i_wr & (i_addr == SCSD_OFS_RC_TRIM);
    assign hi_open = wr_osc & i_wr_be[1] & (r_r.hi_unlock == 2'h2);
    assign lo_open = wr_osc & i_wr_be[0] & (r_r.lo_unlock == 2'h2);
    assign switching = (r_r.state != SCSD_ST_IDLE);

    // ================
    // next state
    always_comb begin
        r_nxt = r_r;

        // any write breaks a partial unlock; an opened byte serves one write
        if (i_wr) begin
            if (wr_osc && i_wr_be[1] && r_r.hi_unlock == 2'h0
                    && i_wdata[15:8] == SCSD_KEY_HI_1) begin
                r_nxt.hi_unlock = 2'h1;
            end else if (wr_osc && i_wr_be[1] && r_r.hi_unlock == 2'h1
                    && i_wdata[15:8] == SCSD_KEY_HI_2) begin
                r_nxt.hi_unlock = 2'h2;
            end else begin
                r_nxt.hi_unlock = 2'h0;
            end
            if (wr_osc && i_wr_be[0] && r_r.lo_unlock == 2'h0
                    && i_wdata[7:0] == SCSD_KEY_LO_1) begin
                r_nxt.lo_unlock = 2'h1;
            end else if (wr_osc && i_wr_be[0] && r_r.lo_unlock == 2'h1
                    && i_wdata[7:0] == SCSD_KEY_LO_2) begin
                r_nxt.lo_unlock = 2'h2;
            end else begin
                r_nxt.lo_unlock = 2'h0;
            end
        end

        // upper byte: only the requested source is writable
        if (hi_open && !frozen) begin
            r_nxt.requested_source_sel = i_wdata[SCSD_POS_REQ +: 3];
        end

        // lower byte
        if (lo_open) begin
            if (i_wdata[SCSD_POS_FREEZE]) begin
                r_nxt.selection_freeze = 1'b1;
            end
            if (!i_wdata[SCSD_POS_CF]) begin
                r_nxt.clock_fail_flag = 1'b0;
            end
            r_nxt.secondary_drive_strength = i_wdata[SCSD_POS_SDRV];
            r_nxt.secondary_osc_enable = i_wdata[SCSD_POS_SEN];
            if (i_wdata[SCSD_POS_SWREQ] && !frozen) begin
                r_nxt.switch_request = 1'b1;
            end
        end

        if (wr_div && i_wr_be[1]) begin
            r_nxt.slowdown_exit_on_irq = i_wdata[SCSD_POS_ROI];
            r_nxt.slowdown_ratio = i_wdata[SCSD_POS_DOZE +: 3];
            r_nxt.slowdown_enable = i_wdata[SCSD_POS_SLOWDOWN_ENABLE];
            r_nxt.fast_rc_postscaler = i_wdata[SCSD_POS_FAST_RC_POSTSCALER +: 3];
        end
        if (wr_trim && i_wr_be[0]) begin
            r_nxt.rc_trim_value = i_wdata[5:0];
        end

        // an interrupt beats a same-cycle software write
        if (i_irq && r_r.slowdown_exit_on_irq) begin
            r_nxt.slowdown_enable = 1'b0;
        end

        // switch sequencer
        case (r_r.state)
            SCSD_ST_IDLE: begin
                if (r_r.switch_request) begin
                    r_nxt.state = SCSD_ST_CHECK;
                end
            end
            SCSD_ST_CHECK: begin
                if (r_r.requested_source_sel == r_r.current_source_sel) begin
                    r_nxt.switch_request = 1'b0;
                    r_nxt.state = SCSD_ST_IDLE;
                end else begin
                    r_nxt.clock_fail_flag = 1'b0;
                    r_nxt.state = SCSD_ST_WAIT;
                end
            end
            SCSD_ST_WAIT: begin
                // wait for the new source, and the PLL when it is used
                if (i_src_ready[r_r.requested_source_sel]
                        && (!scsd_uses_pll(r_r.requested_source_sel)
                        || i_pll_lock)) begin
                    r_nxt.settle_cnt = 4'h0;
                    r_nxt.state = SCSD_ST_SETTLE;
                end
            end
            SCSD_ST_SETTLE: begin
                if (i_new_clk_tick) begin
                    r_nxt.settle_cnt = r_r.settle_cnt + 4'h1;
                    if (r_r.settle_cnt == SCSD_SETTLE_CYCLES - 4'h1) begin
                        r_nxt.state = SCSD_ST_SYNC;
                    end
                end
            end
            SCSD_ST_SYNC: begin
                // commit only on a clean old-clock edge
                if (i_old_clk_tick) begin
                    r_nxt.current_source_sel = r_r.requested_source_sel;
                    r_nxt.switch_request = 1'b0;
                    r_nxt.state = SCSD_ST_IDLE;
                end
            end
            default: begin
                r_nxt.state = SCSD_ST_IDLE;
            end
        endcase

        // a fail event beats a same-cycle clear
        if (i_clock_fail && monitor_on) begin
            r_nxt.clock_fail_flag = 1'b1;
        end

        // held idle unless switching is configured
        if (!switch_allowed) begin
            r_nxt.switch_request = 1'b0;
            r_nxt.state = SCSD_ST_IDLE;
        end

        // load the configuration once after reset
        if (!r_r.cfg_done) begin
            r_nxt.cfg_done = 1'b1;
            r_nxt.current_source_sel = i_cfg_initial_source;
            r_nxt.requested_source_sel = i_cfg_initial_source;
            r_nxt.state = SCSD_ST_IDLE;
            r_nxt.switch_request = 1'b0;
        end

        // lock status: zero while switching or on a non-PLL source
        r_nxt.pll_locked = scsd_uses_pll(r_nxt.current_source_sel)
            && (r_nxt.state == SCSD_ST_IDLE)
            && (i_pll_lock || i_pll_timer_done);

        // submode is config-fixed; a switch never alters it
        r_nxt.primary_mode = i_cfg_primary_mode;
        r_nxt.osc_enable = scsd_onehot(r_nxt.current_source_sel);
        if (r_nxt.state != SCSD_ST_IDLE && r_nxt.state != SCSD_ST_CHECK) begin
            r_nxt.osc_enable = r_nxt.osc_enable
                | scsd_onehot(r_nxt.requested_source_sel);
        end
        if (r_nxt.secondary_osc_enable) begin
            r_nxt.osc_enable[SCSD_SRC_SEC] = 1'b1;
        end
        r_nxt.pll_enable = r_nxt.osc_enable[SCSD_SRC_FRC_PLL]
            | r_nxt.osc_enable[SCSD_SRC_PRI_PLL];
        r_nxt.sec_high_power = !i_cfg_secondary_digital
            && (r_nxt.secondary_drive_strength
            || i_cfg_secondary_high_power);
        r_nxt.fsm_enable = monitor_on;
        r_nxt.ratio_out = r_nxt.slowdown_enable
            ? r_nxt.slowdown_ratio : 3'h0;
        if (r_nxt.current_source_sel == SCSD_SRC_FRC_DIV
                || r_nxt.current_source_sel == SCSD_SRC_LPFRC_DIV) begin
            // top code jumps to 256, not 128
            r_nxt.div_shift = (r_nxt.fast_rc_postscaler == 3'h7)
                ? SCSD_DIV256_SHIFT
                : {1'b0, r_nxt.fast_rc_postscaler};
        end else begin
            r_nxt.div_shift = 4'h0;
        end

        // read data stand for one cycle only
        r_nxt.rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                SCSD_OFS_OSC_CTRL: begin
                    r_nxt.rdata = {1'b0, r_r.current_source_sel, 1'b0,
                        r_r.requested_source_sel, r_r.selection_freeze,
                        1'b0, r_r.pll_locked, 1'b0, r_r.clock_fail_flag,
                        r_r.secondary_drive_strength,
                        r_r.secondary_osc_enable,
                        r_r.switch_request};
                end
                SCSD_OFS_CLK_DIV: begin
                    r_nxt.rdata = {r_r.slowdown_exit_on_irq,
                        r_r.slowdown_ratio, r_r.slowdown_enable,
                        r_r.fast_rc_postscaler, 8'h00};
                end
                SCSD_OFS_RC_TRIM: begin
                    r_nxt.rdata = {10'h000, r_r.rc_trim_value};
                end
                default: begin
                    r_nxt.rdata = 16'h0000;
                end
            endcase
        end
    end

    // ================
    // state register
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r_r.cfg_done <= 1'b0;
            r_r.current_source_sel <= SCSD_RST_SRC;
            r_r.requested_source_sel <= SCSD_RST_SRC;
            r_r.switch_request <= 1'b0;
            r_r.selection_freeze <= 1'b0;
            r_r.pll_locked <= 1'b0;
            r_r.clock_fail_flag <= 1'b0;
            r_r.secondary_drive_strength <= 1'b0;
            r_r.secondary_osc_enable <= 1'b0;
            r_r.slowdown_exit_on_irq <= 1'b0;
            r_r.slowdown_ratio <= SCSD_RST_DOZE;
            r_r.slowdown_enable <= 1'b0;
            r_r.fast_rc_postscaler <= SCSD_RST_FAST_RC_POSTSCALER;
            r_r.rc_trim_value <= SCSD_RST_TRIM;
            r_r.hi_unlock <= 2'h0;
            r_r.lo_unlock <= 2'h0;
            r_r.state <= SCSD_ST_IDLE;
            r_r.settle_cnt <= 4'h0;
            r_r.rdata <= 16'h0000;
            r_r.primary_mode <= SCSD_PM_INT;
            r_r.osc_enable <= 8'h80;
            r_r.pll_enable <= 1'b0;
            r_r.sec_high_power <= 1'b0;
            r_r.fsm_enable <= 1'b0;
            r_r.ratio_out <= 3'h0;
            r_r.div_shift <= 4'h1;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ================
    // outputs
    assign o_rdata = r_r.rdata;
    assign o_source_sel = r_r.current_source_sel;
    assign o_primary_mode = r_r.primary_mode;
    assign o_osc_enable = r_r.osc_enable;
    assign o_pll_enable = r_r.pll_enable;
    assign o_secondary_high_power = r_r.sec_high_power;
    assign o_fail_monitor_enable = r_r.fsm_enable;
    assign o_slowdown_ratio = r_r.ratio_out;
    assign o_rc_div_shift = r_r.div_shift;
    assign o_rc_trim_value = r_r.rc_trim_value;
endmodule

// ===== scsd_checker.sv
// concurrent checks on the ports of the clock select and divide block
module scsd_checker (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [1:0] i_addr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [1:0] i_cfg_primary_mode,
    input wire logic [1:0] i_cfg_switch_enable,
    input wire logic i_cfg_secondary_digital,
    input wire logic i_old_clk_tick,
    input wire logic [2:0] o_source_sel,
    input wire logic [1:0] o_primary_mode,
    input wire logic o_secondary_high_power,
    input wire logic o_fail_monitor_enable,
    input wire logic [3:0] o_rc_div_shift
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // ================
    // read port
    a_rdata_idle: assert property (!$past(i_rd)
        |-> o_rdata == 16'h0000) else $error("stray read data");
    a_unmapped_zero: assert property ($past(i_rd)
        && $past(i_addr) == 2'h3 |-> o_rdata == 16'h0000)
        else $error("unmapped not zero");
    a_osc_reserved: assert property ($past(i_rd)
        && $past(i_addr) == 2'h0 |-> (o_rdata & 16'h8850) == 16'h0000)
        else $error("reserved bit set");
    a_src_readback: assert property ($past(i_rd)
        && $past(i_addr) == 2'h0 |-> o_rdata[14:12] == $past(o_source_sel))
        else $error("source readback");
    a_lock_pll_only: assert property ($past(i_rd)
        && $past(i_addr) == 2'h0 && o_rdata[5]
        |-> $past(o_source_sel) inside {3'h1, 3'h3})
        else $error("lock off pll");
    // ================
    // source selection and configuration
    // a change needs an old-clock tick
    a_src_change: assert property ($past(i_resetn, 2)
        && $changed(o_source_sel) |-> !i_cfg_switch_enable[1]
        && ($past(i_old_clk_tick) || $past(i_old_clk_tick, 2)
        || $past(i_old_clk_tick, 3))) else $error("bad source change");
    a_monitor_cfg: assert property ($past(i_resetn)
        |-> o_fail_monitor_enable == ($past(i_cfg_switch_enable) == 2'h0))
        else $error("monitor enable wrong");
    a_primary_fixed: assert property ($past(i_resetn)
        |-> o_primary_mode == $past(i_cfg_primary_mode))
        else $error("submode changed");
    a_sec_power: assert property ($past(i_resetn)
        && o_secondary_high_power |-> !$past(i_cfg_secondary_digital))
        else $error("drive on digital");
    a_shift_range: assert property (o_rc_div_shift <= 4'h8
        && o_rc_div_shift != 4'h7) else $error("shift range");
endmodule

// ===== scsd_osc_model.sv
// behavioural oscillators, pll and fail monitor on the far side
module scsd_osc_model #(
    parameter int READY_DELAY = 4,
    parameter int LOCK_DELAY = 6
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_osc_enable,
    input wire logic i_pll_enable,
    input wire logic i_fail_req,
    output logic [7:0] o_src_ready,
    output logic o_pll_lock,
    output logic o_pll_timer_done,
    output logic o_new_clk_tick,
    output logic o_old_clk_tick,
    output logic o_clock_fail
);
    timeunit 1ns;
    timeprecision 1ps;
    int on_cnt [8];
    int lock_cnt;
    int tick_cnt;
    // no timer, so a missed lock wait cannot hide behind it
    assign o_pll_timer_done = 1'b0;
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int k = 0; k < 8; k++) on_cnt[k] <= 0;
            {o_src_ready, o_pll_lock, o_clock_fail} <= 10'h000;
            {o_new_clk_tick, o_old_clk_tick} <= 2'h0;
            lock_cnt <= 0;
            tick_cnt <= 0;
        end else begin
            for (int k = 0; k < 8; k++) begin
                on_cnt[k] <= i_osc_enable[k] ? on_cnt[k] + 1 : 0;
                o_src_ready[k] <= i_osc_enable[k] && on_cnt[k] >= READY_DELAY;
            end
            lock_cnt <= i_pll_enable ? lock_cnt + 1 : 0;
            o_pll_lock <= i_pll_enable && lock_cnt >= LOCK_DELAY;
            tick_cnt <= tick_cnt + 1;
            o_new_clk_tick <= (tick_cnt % 2) == 1;
            o_old_clk_tick <= (tick_cnt % 5) == 0;
            o_clock_fail <= i_fail_req;
        end
    end
endmodule

// ===== scsd_top_test.sv
// self-checking bench for the clock select and divide block
module scsd_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import scsd_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic [1:0] wr_be = 2'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] cfg_init = SCSD_RST_SRC;
    logic [1:0] cfg_sw = 2'h0;
    logic irq = 1'b0;
    logic fail_req = 1'b0;
    logic [15:0] rdata, d, r;
    logic [7:0] src_ready, osc_en;
    logic pll_lock, timer_done, new_tick, old_tick, clock_fail, pll_en;
    logic sec_hp, fmon;
    logic [2:0] source_sel, ratio;
    logic [1:0] primary_mode;
    logic [3:0] shift;
    logic [5:0] trim;
    logic [2:0] seq [7] = '{3'h0, 3'h3, 3'h3, 3'h6, 3'h2, 3'h5, 3'h1};
    logic sdig = 1'b0;
    int mismatches = 0;
    int total_checks = 0;
    int seed;
    scsd_top scsd_top_i (.i_sys_clk(sys_clk), .i_resetn(resetn),
        .i_addr(addr), .i_wdata(wdata), .i_wr_be(wr_be), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_cfg_initial_source(cfg_init),
        .i_cfg_primary_mode(SCSD_PM_HS), .i_cfg_switch_enable(cfg_sw),
        .i_cfg_secondary_high_power(1'b0), .i_cfg_secondary_digital(sdig),
        .i_src_ready(src_ready), .i_pll_lock(pll_lock),
        .i_pll_timer_done(timer_done), .i_new_clk_tick(new_tick),
        .i_old_clk_tick(old_tick), .i_clock_fail(clock_fail), .i_irq(irq),
        .o_source_sel(source_sel), .o_primary_mode(primary_mode),
        .o_osc_enable(osc_en), .o_pll_enable(pll_en),
        .o_secondary_high_power(sec_hp), .o_fail_monitor_enable(fmon),
        .o_slowdown_ratio(ratio), .o_rc_div_shift(shift),
        .o_rc_trim_value(trim));
    scsd_osc_model scsd_osc_model_i (.i_sys_clk(sys_clk), .i_resetn(resetn),
        .i_osc_enable(osc_en), .i_pll_enable(pll_en), .i_fail_req(fail_req),
        .o_src_ready(src_ready), .o_pll_lock(pll_lock),
        .o_pll_timer_done(timer_done), .o_new_clk_tick(new_tick),
        .o_old_clk_tick(old_tick), .o_clock_fail(clock_fail));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    // ================
    // bus tasks and expectations
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // a gap edge keeps one assignment per time step
    task automatic wr_reg(input logic [1:0] a, be, input logic [15:0] v);
        @(posedge sys_clk);
        {wr, addr, wr_be, wdata} <= {1'b1, a, be, v};
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        {rd, addr} <= {1'b1, a};
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic do_switch(input logic [2:0] n);
        int k;
        wr_reg(SCSD_OFS_OSC_CTRL, 2'h2, {SCSD_KEY_HI_1, 8'h00});
        wr_reg(SCSD_OFS_OSC_CTRL, 2'h2, {SCSD_KEY_HI_2, 8'h00});
        wr_reg(SCSD_OFS_OSC_CTRL, 2'h2, {5'h00, n, 8'h00});
        wr_reg(SCSD_OFS_OSC_CTRL, 2'h1, {8'h00, SCSD_KEY_LO_1});
        wr_reg(SCSD_OFS_OSC_CTRL, 2'h1, {8'h00, SCSD_KEY_LO_2});
        wr_reg(SCSD_OFS_OSC_CTRL, 2'h1, 16'h0007);
        for (k = 0; k < 100; k++) begin
            rd_reg(SCSD_OFS_OSC_CTRL, d);
            if (d[0] === 1'b0) break;
        end
        if (k == 100) begin
            mismatches++;
            finish_test();
        end
    endtask
    function automatic logic [15:0] osc_val(input logic [2:0] cur, req,
        input logic fr, lk, cf, input logic [2:0] lo);
        return {1'b0, cur, 1'b0, req, fr, 1'b0, lk, 1'b0, cf, lo};
    endfunction
    function automatic logic [15:0] exp_shift(input logic [2:0] c);
        return (c == 3'h7) ? 16'h0008 : 16'(c);
    endfunction
    // ================
    // main sequence
    initial begin
        seed = 54371;
        do_reset();
        rd_reg(SCSD_OFS_OSC_CTRL, d);
        chk(d, osc_val(3'h7, 3'h7, 1'b0, 1'b0, 1'b0, 3'h0));
        rd_reg(SCSD_OFS_CLK_DIV, d);
        chk(d, 16'h3100);
        rd_reg(SCSD_OFS_RC_TRIM, d);
        chk(d, 16'h0000);
        rd_reg(2'h3, d);
        chk(d, 16'h0000);
        chk(16'(shift), 16'h0001);
        chk(16'(fmon), 16'h0001);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            r = 16'($random(seed));
            r[14:12] = 3'(i);
            r[10:8] = 3'(7 - i);
            wr_reg(SCSD_OFS_CLK_DIV, 2'h3, r);
            rd_reg(SCSD_OFS_CLK_DIV, d);
            chk(d, r & 16'hFF00);
            chk(16'(ratio), r[11] ? 16'(i) : 16'h0000);
            chk(16'(shift), exp_shift(r[10:8]));
            wr_reg(SCSD_OFS_RC_TRIM, 2'h1, r);
            rd_reg(SCSD_OFS_RC_TRIM, d);
            chk(d, r & 16'h003F);
            chk(16'(trim), r & 16'h003F);
        end
        $display("test registers done");
        wr_reg(SCSD_OFS_CLK_DIV, 2'h3, 16'h8B00);
        @(posedge sys_clk) irq <= 1'b1;
        @(posedge sys_clk) irq <= 1'b0;
        rd_reg(SCSD_OFS_CLK_DIV, d);
        chk(d, 16'h8300);
        chk(16'(ratio), 16'h0000);
        wr_reg(SCSD_OFS_CLK_DIV, 2'h3, 16'h3A00);
        @(posedge sys_clk) irq <= 1'b1;
        @(posedge sys_clk) irq <= 1'b0;
        rd_reg(SCSD_OFS_CLK_DIV, d);
        chk(d, 16'h3A00);
        chk(16'(ratio), 16'h0003);
        $display("test slowdown done");
        wr_reg(SCSD_OFS_OSC_CTRL, 2'h2, 16'h0000);
        rd_reg(SCSD_OFS_OSC_CTRL, d);
        chk(d, osc_val(3'h7, 3'h7, 1'b0, 1'b0, 1'b0, 3'h0));
        for (int i = 0; i < 7; i++) begin
            do_switch(seq[i]);
            chk(d, osc_val(seq[i], seq[i], 1'b0, seq[i] inside {3'h1, 3'h3},
                1'b0, 3'h6));
            chk(16'(pll_en), 16'(seq[i] inside {3'h1, 3'h3}));
            chk(16'(source_sel), 16'(seq[i]));
            chk(16'(shift), (seq[i] == 3'h6) ? 16'h0002 : 16'h0000);
            chk(16'(primary_mode), 16'(SCSD_PM_HS));
            chk(16'(osc_en[4]), 16'h0001);
            chk(16'(sec_hp), 16'h0001);
        end
        $display("test switching done");
        @(posedge sys_clk) fail_req <= 1'b1;
        @(posedge sys_clk) fail_req <= 1'b0;
        rd_reg(SCSD_OFS_OSC_CTRL, d);
        chk(16'(d[3]), 16'h0001);
        do_switch(3'h7);
        chk(d, osc_val(3'h7, 3'h7, 1'b0, 1'b0, 1'b0, 3'h6));
        chk(16'(shift), 16'h0002);
        wr_reg(SCSD_OFS_OSC_CTRL, 2'h1, {8'h00, SCSD_KEY_LO_1});
        wr_reg(SCSD_OFS_OSC_CTRL, 2'h1, {8'h00, SCSD_KEY_LO_2});
        wr_reg(SCSD_OFS_OSC_CTRL, 2'h1, 16'h0086);
        do_switch(3'h0);
        chk(d, osc_val(3'h7, 3'h7, 1'b1, 1'b0, 1'b0, 3'h6));
        $display("test fail and freeze done");
        cfg_init <= SCSD_SRC_SEC;
        cfg_sw <= 2'h2;
        sdig <= 1'b1;
        do_reset();
        rd_reg(SCSD_OFS_OSC_CTRL, d);
        chk(d & 16'h7780, 16'h4400);
        chk(16'(fmon), 16'h0000);
        do_switch(3'h0);
        chk(d & 16'h7001, 16'h4000);
        chk(16'(sec_hp), 16'h0000);
        $display("test switching disabled done");
        finish_test();
    end
endmodule
bind scsd_top scsd_checker scsd_checker_i (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cfg_primary_mode(i_cfg_primary_mode),
    .i_cfg_switch_enable(i_cfg_switch_enable),
    .i_cfg_secondary_digital(i_cfg_secondary_digital),
    .i_old_clk_tick(i_old_clk_tick), .o_source_sel(o_source_sel),
    .o_primary_mode(o_primary_mode),
    .o_secondary_high_power(o_secondary_high_power),
    .o_fail_monitor_enable(o_fail_monitor_enable),
    .o_rc_div_shift(o_rc_div_shift));
